// *** fcac_checker_properties.sv ***
`default_nettype none
// ==========
// Port-level checks of the flash sequencer
module fcac_checker #(
    parameter int PROGRAM_CYC = 8,
    parameter int ERASE_CYC = 20
) (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic ctrl_we_i,
    input wire logic [3:0] ctrl_cmd_enable_i,
    input wire logic ctrl_bank_sel_i,
    input wire logic [3:0] command_enable_field_o,
    input wire logic bank_sel_o,
    input wire logic ram_loader_i,
    input wire logic watchdog_disable_o,
    input wire logic cpu_req_i,
    input wire logic cpu_we_i,
    input wire logic cpu_fetch_from_flash_i,
    input wire logic [7:0] cpu_rdata_o,
    input wire logic cpu_refused_o,
    input wire logic busy_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    logic [fcac_pkg::FCAC_CNT_W-1:0] cnt_q;
    logic rd_w;
    // Busy length counter, as wide as the design's timer so full-length runs fit
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= busy_o ? cnt_q + 1'b1 : '0;
        end
    end
    assign rd_w = cpu_req_i && !cpu_we_i;
    refuse_busy_a: assert property (rd_w && busy_o |=> cpu_refused_o)
        else $error("no refusal");
    refuse_idle_a: assert property (rd_w && !busy_o |=> !cpu_refused_o)
        else $error("bad refusal");
    fetch_blank_a: assert property (rd_w && cpu_fetch_from_flash_i && busy_o |=>
        cpu_rdata_o == 8'h00) else $error("fetch data leaked");
    toggle_only_a: assert property (rd_w && busy_o |=>
        (cpu_rdata_o & 8'hBF) == 8'h00) else $error("busy read not toggle only");
    field_load_a: assert property (ctrl_we_i |=>
        command_enable_field_o == $past(ctrl_cmd_enable_i)
        && bank_sel_o == $past(ctrl_bank_sel_i))
        else $error("field not loaded");
    field_hold_a: assert property (!ctrl_we_i |=>
        $stable(command_enable_field_o) && $stable(bank_sel_o)) else $error("field moved");
    locked_idle_a: assert property (
        command_enable_field_o != fcac_pkg::FCAC_CMD_ENABLE && !busy_o |=> !busy_o)
        else $error("locked start");
    flash_fetch_a: assert property (
        cpu_req_i && cpu_we_i && cpu_fetch_from_flash_i && !busy_o |=> !busy_o)
        else $error("flash code started op");
    busy_len_a: assert property ($fell(busy_o) |->
        cnt_q == PROGRAM_CYC + 1 || cnt_q == ERASE_CYC + 1) else $error("busy length");
    wdt_on_a: assert property ($rose(ram_loader_i) |-> ##[2:4] watchdog_disable_o)
        else $error("watchdog left on");
endmodule
`default_nettype wire

// *** fcac_cpu_model.sv ***
`default_nettype none
// ==========
// CPU running the control program from RAM, interrupts already masked
module fcac_cpu_model (
    input wire logic clk_i,
    input wire logic [7:0] rdata_i,
    input wire logic refused_i,
    output logic req_o,
    output logic we_o,
    output logic fetch_o,
    output logic [15:0] addr_o,
    output logic [7:0] wdata_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {req_o, we_o, fetch_o, addr_o, wdata_o} = 27'h0000000;
    // One access; released lines show the inverse so stale values never pass
    task xfer(input logic w, f, input logic [15:0] a, input logic [7:0] d,
              output logic [7:0] q, output logic r);
        @(posedge clk_i) #10;
        {req_o, we_o, fetch_o, addr_o, wdata_o} = {1'b1, w, f, a, d};
        @(posedge clk_i) #10;
        q = rdata_i;
        r = refused_i;
        {req_o, addr_o, wdata_o} = {1'b0, ~a, ~d};
    endtask
    // Poll one address until two reads agree, bounded
    task poll(input logic [15:0] a, output logic [7:0] q);
        logic [7:0] p;
        logic r;
        xfer(1'b0, 1'b0, a, 8'h00, p, r);
        xfer(1'b0, 1'b0, a, 8'h00, q, r);
        for (int n = 0; n < 100 && q !== p; n++) begin
            p = q;
            xfer(1'b0, 1'b0, a, 8'h00, q, r);
        end
    endtask
endmodule
`default_nettype wire

// *** fcac_op_timer.sv ***
`default_nettype none
// ==========================================
// Busy timer for one array operation
module fcac_op_timer #(
    parameter int CNT_W = 20
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic start_i,
    input wire logic [CNT_W-1:0] cycles_i,
    output logic busy_o,
    output logic done_o
);
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic busy_q;
    wire last_w = busy_q && (cnt_q == {{(CNT_W-1){1'b0}}, 1'b1});

    // Counts down; a start while busy is ignored
    assign cnt_d = (start_i && !busy_q) ? cycles_i : (busy_q ? cnt_q - 1'b1 : cnt_q);
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= '0;
            busy_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            busy_q <= (start_i && !busy_q) ? 1'b1 : (last_w ? 1'b0 : busy_q);
        end
    end
    assign busy_o = busy_q;
    assign done_o = last_w;
endmodule
`default_nettype wire

// *** fcac_pkg.sv ***
`default_nettype none
package fcac_pkg;
    // Command-enable field patterns
    localparam logic [3:0] FCAC_CMD_ENABLE = 4'h3;
    localparam logic [3:0] FCAC_CMD_DISABLE = 4'hC;
    localparam logic [3:0] FCAC_CMD_RESET_VAL = 4'hC;
    localparam logic FCAC_BANK_RESET_VAL = 1'b0;
    // Unlock addresses and data of the command sequences
    localparam logic [11:0] FCAC_UNLOCK_ADDR1 = 12'h555;
    localparam logic [11:0] FCAC_UNLOCK_ADDR2 = 12'hAAA;
    localparam logic [7:0] FCAC_UNLOCK_DATA1 = 8'hAA;
    localparam logic [7:0] FCAC_UNLOCK_DATA2 = 8'h55;
    localparam logic [7:0] FCAC_CMD_PROGRAM = 8'hA0;
    localparam logic [7:0] FCAC_CMD_ERASE_SETUP = 8'h80;
    localparam logic [7:0] FCAC_CMD_SECTOR = 8'h30;
    localparam logic [7:0] FCAC_CMD_CHIP = 8'h10;
    localparam logic [7:0] FCAC_CMD_PROTECT = 8'hA5;
    localparam logic [15:0] FCAC_PROTECT_ADDR = 16'hFF7F;
    localparam logic [7:0] FCAC_ERASED_BYTE = 8'hFF;
    localparam int FCAC_TOGGLE_BIT = 6;
    localparam int FCAC_SECTOR_SHIFT = 12;
    // Timing, figures as printed, cycles at the system clock rate
    localparam int FCAC_CLK_HZ = 10_000_000;
    localparam int FCAC_PROGRAM_US = 40;
    localparam int FCAC_ERASE_MS = 30;
    localparam int FCAC_PROGRAM_CYC = FCAC_PROGRAM_US * (FCAC_CLK_HZ / 1_000_000);
    localparam int FCAC_ERASE_CYC = FCAC_ERASE_MS * (FCAC_CLK_HZ / 1_000);
    localparam int FCAC_CNT_W = 20;
endpackage
`default_nettype wire

// *** fcac_top.sv ***
`default_nettype none
// Function
// - While an operation runs, normal reads and fetches of the array are refused.
// - Writes while the CPU fetches from flash start no command.
// - Byte reads in one transfer; byte program by a multi-write sequence.
// - Erase the whole array or one 4-kbyte sector.
// - Pattern 0011 in the command-enable field lets sequences be accepted.
// - Pattern 1100 in the command-enable field blocks command sequences.
// - The watchdog is left disabled when the RAM loader is entered.
// - The fourth program write carries address and data; done within 40 us.
// - Chip erase lasts about 30 ms and leaves every byte all ones.
// - Reads during an operation toggle bit 6, the first one returning 1.
module fcac_top #(
    parameter int ARRAY_AW = 16,
    parameter int PROGRAM_CYC = fcac_pkg::FCAC_PROGRAM_CYC,
    parameter int ERASE_CYC = fcac_pkg::FCAC_ERASE_CYC
) (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    // Flash control register fields
    input wire logic ctrl_we_i,
    input wire logic [3:0] ctrl_cmd_enable_i,
    input wire logic ctrl_bank_sel_i,
    output logic [3:0] command_enable_field_o,
    output logic bank_sel_o,
    // Boot mode strap: RAM loader entered
    input wire logic ram_loader_i,
    output logic watchdog_disable_o,
    // CPU access to the flash window
    input wire logic cpu_req_i,
    input wire logic cpu_we_i,
    input wire logic cpu_fetch_from_flash_i,
    input wire logic [ARRAY_AW-1:0] cpu_addr_i,
    input wire logic [7:0] cpu_wdata_i,
    output logic [7:0] cpu_rdata_o,
    output logic cpu_refused_o,
    output logic busy_o
);
    localparam int CW = fcac_pkg::FCAC_CNT_W;
    localparam int SW = ARRAY_AW - fcac_pkg::FCAC_SECTOR_SHIFT;
    localparam int SECT_N = 1 << SW;
    localparam int SECT_SZ = 1 << fcac_pkg::FCAC_SECTOR_SHIFT;

    typedef enum logic [2:0] {
        FCAC_IDLE, FCAC_U1, FCAC_U2, FCAC_PROG, FCAC_E1, FCAC_E2, FCAC_E3
    } fcac_seq_t;

    // ==========================================
    // Reset release and strap sampling
    logic rst_s1_q, rst_n_q;
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_s1_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q <= rst_s1_q;
        end
    end

    logic ldr_s1_q, ldr_s2_q, wdt_dis_q;
    // Strap passes two flops; the watchdog kill follows the synced level
    always_ff @(posedge sys_clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ldr_s1_q <= 1'b0;
            ldr_s2_q <= 1'b0;
            wdt_dis_q <= 1'b0;
        end else begin
            ldr_s1_q <= ram_loader_i;
            ldr_s2_q <= ldr_s1_q;
            wdt_dis_q <= ldr_s2_q;
        end
    end
    assign watchdog_disable_o = wdt_dis_q;

    // ==========================================
    // Flash control register
    logic [3:0] cmd_en_q;
    logic bank_q;
    always_ff @(posedge sys_clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            cmd_en_q <= fcac_pkg::FCAC_CMD_RESET_VAL;
            bank_q <= fcac_pkg::FCAC_BANK_RESET_VAL;
        end else if (ctrl_we_i) begin
            cmd_en_q <= ctrl_cmd_enable_i;
            bank_q <= ctrl_bank_sel_i;
        end
    end
    assign command_enable_field_o = cmd_en_q;
    assign bank_sel_o = bank_q;
    // Anything but the enable pattern blocks, so 1100 and stray values act alike
    wire cmd_open_w = (cmd_en_q == fcac_pkg::FCAC_CMD_ENABLE);

    // ==========================================
    // Array storage
    logic [7:0] sect_rd_w [0:SECT_N-1]; // Byte at the read address, one per sector
    logic busy_w, done_w;
    logic op_start_q;
    logic [CW-1:0] op_cyc_q;
    logic [1:0] op_kind_q; // 0 program, 1 sector, 2 chip, 3 protect
    logic [ARRAY_AW-1:0] op_addr_q;
    logic [7:0] op_data_q;
    logic protect_q;

    // A write only counts from RAM/ROM code and with the field open
    wire wr_w = cpu_req_i && cpu_we_i && !cpu_fetch_from_flash_i && cmd_open_w;
    wire [11:0] low_w = cpu_addr_i[11:0];
    wire is_a1_w = (low_w == fcac_pkg::FCAC_UNLOCK_ADDR1);
    wire is_a2_w = (low_w == fcac_pkg::FCAC_UNLOCK_ADDR2);
    wire [ARRAY_AW-1:0] pa_w = op_addr_q;
    wire [11:0] pofs_w = op_addr_q[11:0];

    fcac_op_timer #(.CNT_W(CW)) u_timer (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_q),
        .start_i(op_start_q),
        .cycles_i(op_cyc_q),
        .busy_o(busy_w),
        .done_o(done_w)
    );
    assign busy_o = busy_w || op_start_q;

    // ==========================================
    // Command sequence decoder
    fcac_seq_t st_q, st_d;
    always_comb begin
        st_d = st_q;
        case (st_q)
            FCAC_IDLE: st_d = (is_a1_w && cpu_wdata_i == fcac_pkg::FCAC_UNLOCK_DATA1)
                              ? FCAC_U1 : FCAC_IDLE;
            FCAC_U1: st_d = (is_a2_w && cpu_wdata_i == fcac_pkg::FCAC_UNLOCK_DATA2)
                            ? FCAC_U2 : FCAC_IDLE;
            FCAC_U2: begin
                if (is_a1_w && cpu_wdata_i == fcac_pkg::FCAC_CMD_PROGRAM) begin
                    st_d = FCAC_PROG;
                end else if (is_a1_w && cpu_wdata_i == fcac_pkg::FCAC_CMD_ERASE_SETUP) begin
                    st_d = FCAC_E1;
                end else begin
                    st_d = FCAC_IDLE;
                end
            end
            FCAC_E1: st_d = (is_a1_w && cpu_wdata_i == fcac_pkg::FCAC_UNLOCK_DATA1)
                            ? FCAC_E2 : FCAC_IDLE;
            FCAC_E2: st_d = (is_a2_w && cpu_wdata_i == fcac_pkg::FCAC_UNLOCK_DATA2)
                            ? FCAC_E3 : FCAC_IDLE;
            default: st_d = FCAC_IDLE;
        endcase
    end

    // Final write of each sequence launches the operation
    wire go_prog_w = wr_w && st_q == FCAC_PROG;
    wire go_sect_w = wr_w && st_q == FCAC_E3 && cpu_wdata_i == fcac_pkg::FCAC_CMD_SECTOR;
    wire go_chip_w = wr_w && st_q == FCAC_E3 && is_a1_w
                     && cpu_wdata_i == fcac_pkg::FCAC_CMD_CHIP;
    wire go_prot_w = wr_w && st_q == FCAC_U2 && is_a1_w
                     && cpu_wdata_i == fcac_pkg::FCAC_CMD_PROTECT;
    wire go_w = go_prog_w || go_sect_w || go_chip_w || go_prot_w;
    wire slow_w = go_sect_w || go_chip_w;

    // Writes during an operation are dropped; the next sequence waits
    always_ff @(posedge sys_clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            st_q <= FCAC_IDLE;
            op_start_q <= 1'b0;
            op_cyc_q <= '0;
            op_kind_q <= 2'h0;
            op_addr_q <= '0;
            op_data_q <= 8'h00;
        end else begin
            op_start_q <= go_w && !busy_o;
            if (!cmd_open_w || busy_o) begin
                st_q <= FCAC_IDLE;
            end else if (wr_w) begin
                st_q <= go_w ? FCAC_IDLE : st_d;
            end
            if (go_w && !busy_o) begin
                op_cyc_q <= slow_w ? CW'(ERASE_CYC) : CW'(PROGRAM_CYC);
                op_kind_q <= go_prog_w ? 2'h0 : (go_sect_w ? 2'h1 : (go_chip_w ? 2'h2 : 2'h3));
                op_addr_q <= cpu_addr_i;
                op_data_q <= cpu_wdata_i;
            end
        end
    end

    // ==========================================
    // Array update at operation end
    // Program ANDs bits so an unerased byte cannot be raised back to one
    // Each sector owns its storage, so only one process ever writes an array
    genvar gs;
    generate
        for (gs = 0; gs < SECT_N; gs++) begin : g_sect
            logic [7:0] sect_q [0:SECT_SZ-1];
            wire sel_w = (pa_w[ARRAY_AW-1:fcac_pkg::FCAC_SECTOR_SHIFT] == SW'(gs));
            wire hit_w = done_w && (op_kind_q == 2'h2 || (op_kind_q == 2'h1 && sel_w));
            wire prog_w = done_w && op_kind_q == 2'h0 && sel_w;
            always_ff @(posedge sys_clk_i) begin
                if (hit_w) begin
                    for (int i = 0; i < SECT_SZ; i++) begin
                        sect_q[i] <= fcac_pkg::FCAC_ERASED_BYTE;
                    end
                end else if (prog_w) begin
                    sect_q[pofs_w] <= sect_q[pofs_w] & op_data_q;
                end
            end
            assign sect_rd_w[gs] = sect_q[low_w];
        end
    endgenerate

    always_ff @(posedge sys_clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            protect_q <= 1'b0;
        end else if (done_w && op_kind_q == 2'h3) begin
            protect_q <= 1'b1;
        end else if (done_w && op_kind_q == 2'h2) begin
            protect_q <= 1'b0; // Chip erase clears protection
        end
    end

    // ==========================================
    // Read path and toggle bit
    logic [7:0] rdata_q;
    logic tog_q, refused_q;
    wire rd_w = cpu_req_i && !cpu_we_i;
    wire [7:0] poll_w = {1'b0, tog_q, 6'h00};
    wire [7:0] rbyte_w = sect_rd_w[cpu_addr_i[ARRAY_AW-1:fcac_pkg::FCAC_SECTOR_SHIFT]];
    always_ff @(posedge sys_clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rdata_q <= 8'h00;
            tog_q <= 1'b1;
            refused_q <= 1'b0;
        end else begin
            refused_q <= rd_w && busy_o;
            if (!busy_o) begin
                tog_q <= 1'b1;
            end else if (rd_w && !cpu_fetch_from_flash_i) begin
                tog_q <= ~tog_q;
            end
            if (rd_w && busy_o) begin
                rdata_q <= cpu_fetch_from_flash_i ? 8'h00 : poll_w;
            end else if (rd_w) begin
                rdata_q <= rbyte_w;
            end
        end
    end
    assign cpu_rdata_o = rdata_q;
    assign cpu_refused_o = refused_q;
endmodule
`default_nettype wire

// *** flash_command_access_control_bench.sv ***
`default_nettype none
module flash_command_access_control_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk_i = 1'b0, nrst_i = 1'b0, ctrl_we_i = 1'b0, ctrl_bank_sel_i = 1'b0;
    logic ram_loader_i = 1'b0, cpu_req_i, cpu_we_i, cpu_fetch_from_flash_i, r;
    logic [3:0] ctrl_cmd_enable_i = 4'hC, command_enable_field_o;
    logic [15:0] cpu_addr_i;
    logic [7:0] cpu_wdata_i, cpu_rdata_o, q;
    logic bank_sel_o, watchdog_disable_o, cpu_refused_o, busy_o;
    int error_cnt = 0, checks_done = 0;
    always #50 sys_clk_i = ~sys_clk_i;
    // Short operation counts keep the run brief
    fcac_top #(.PROGRAM_CYC(8), .ERASE_CYC(20)) dut (.*);
    fcac_cpu_model u_cpu (.clk_i(sys_clk_i), .rdata_i(cpu_rdata_o), .refused_i(cpu_refused_o),
        .req_o(cpu_req_i), .we_o(cpu_we_i), .fetch_o(cpu_fetch_from_flash_i),
        .addr_o(cpu_addr_i), .wdata_o(cpu_wdata_i));
    task chk(input string n, input logic [15:0] s, e);
        checks_done++;
        if (s !== e) begin
            error_cnt++;
            $display("ERROR %s exp %h seen %h", n, e, s);
        end
    endtask
    task give_verdict;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task ctl(input logic [3:0] e, input logic b);
        @(posedge sys_clk_i) #10;
        {ctrl_we_i, ctrl_cmd_enable_i, ctrl_bank_sel_i} = {1'b1, e, b};
        @(posedge sys_clk_i) #10;
        ctrl_we_i = 1'b0;
        chk("field", command_enable_field_o, e);
        chk("bank", bank_sel_o, b);
    endtask
    task wr(input logic [15:0] a, input logic [7:0] d, input logic f);
        u_cpu.xfer(1'b1, f, a, d, q, r);
    endtask
    task rd(input logic [15:0] a, input logic f);
        u_cpu.xfer(1'b0, f, a, 8'h00, q, r);
    endtask
    // Unlock pair, then the tail of the chosen command
    task cmd(input logic [7:0] c, input logic [15:0] a, input logic [7:0] d, input logic f);
        wr(16'hF555, 8'hAA, f);
        wr(16'hFAAA, 8'h55, f);
        if (c == 8'hA0) begin
            wr(16'hF555, c, f);
            wr(a, d, f);
        end else if (c == 8'hA5) begin
            wr(16'hF555, c, f);
        end else begin
            wr(16'hF555, 8'h80, f);
            wr(16'hF555, 8'hAA, f);
            wr(16'hFAAA, 8'h55, f);
            wr(c == 8'h30 ? a : 16'hF555, c, f);
        end
    endtask
    initial begin
        #2_000_000;
        error_cnt++;
        give_verdict();
    end
    initial begin
        repeat (2) @(posedge sys_clk_i);
        #10 nrst_i = 1'b1;
        repeat (3) @(posedge sys_clk_i);
        chk("field rst", command_enable_field_o, 4'hC);
        chk("idle rst", {bank_sel_o, watchdog_disable_o, busy_o, cpu_refused_o}, 4'h0);
        cmd(8'hA0, 16'hF000, 8'h00, 1'b0);
        chk("locked", busy_o, 1'b0);
        ctl(4'h3, 1'b0);
        cmd(8'hA0, 16'hF000, 8'h00, 1'b1);
        chk("flash code", busy_o, 1'b0);
        cmd(8'h10, 16'hF555, 8'h10, 1'b0);
        rd(16'hF555, 1'b0);
        chk("toggle 1st", {r, q}, 16'h0140);
        rd(16'hF555, 1'b0);
        chk("toggle 2nd", {r, q}, 16'h0100);
        rd(16'hF555, 1'b1);
        chk("fetch busy", {r, q}, 16'h0100);
        u_cpu.poll(16'hF555, q);
        rd(16'hF000, 1'b0);
        chk("chip erased", q, 8'hFF);
        ctl(4'h3, 1'b1);
        cmd(8'hA0, 16'hE123, 8'h5A, 1'b0);
        u_cpu.poll(16'hE123, q);
        chk("prog E123", q, 8'h5A);
        cmd(8'hA0, 16'hF000, 8'h3F, 1'b0);
        u_cpu.poll(16'hF000, q);
        chk("prog F000", q, 8'h3F);
        cmd(8'h30, 16'hF7AB, 8'h30, 1'b0);
        u_cpu.poll(16'hF000, q);
        chk("sector", q, 8'hFF);
        rd(16'hE123, 1'b0);
        chk("other sector", q, 8'h5A);
        cmd(8'hA5, 16'hF555, 8'h00, 1'b0);
        rd(16'hF555, 1'b0);
        chk("protect busy", {r, q}, 16'h0140);
        u_cpu.poll(16'hF555, q);
        chk("protect done", busy_o, 1'b0);
        ctl(4'hC, 1'b0);
        cmd(8'hA0, 16'hE124, 8'h00, 1'b0);
        chk("relocked", busy_o, 1'b0);
        @(posedge sys_clk_i) #10 ram_loader_i = 1'b1;
        repeat (5) @(posedge sys_clk_i);
        chk("wdt off", watchdog_disable_o, 1'b1);
        give_verdict();
    end
endmodule
bind fcac_top fcac_checker #(.PROGRAM_CYC(PROGRAM_CYC), .ERASE_CYC(ERASE_CYC)) u_chk (.*);
`default_nettype wire
